// ### rbms_host_model.sv
// model of the outside host that works the reset pin
module rbms_host_model
(
    // clock
    input wire logic mclk,
    // command from the bench
    input wire logic pulseGo,
    input wire logic [7:0] pulseLen,
    // pin toward the device, activity flag
    output logic resetPinN,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial
    begin
        resetPinN = 1'b1;
        busy = 1'b0;
    end
    // hold the pin low for the commanded cycles
    always @(posedge mclk)
    begin
        if (pulseGo && !busy)
        begin
            resetPinN <= 1'b0;
            busy <= 1'b1;
            cnt <= pulseLen;
        end
        else if (busy && cnt > 1)
            cnt <= cnt - 1;
        else if (busy)
        begin
            resetPinN <= 1'b1;
            busy <= 1'b0;
        end
    end
endmodule : rbms_host_model

// ### rbms_pkg.sv
// types shared by the reset and boot-mode sequencer
package rbms_pkg;
    // latched reset cause
    typedef enum logic [2:0]
    {
        CAUSE_POWER = 3'h0,
        CAUSE_BROWN = 3'h1,
        CAUSE_PIN = 3'h2,
        CAUSE_WAKE = 3'h3,
        CAUSE_WDOG = 3'h4,
        CAUSE_SOFT = 3'h5
    } rbms_cause_t;
    // boot state of the chip
    typedef enum logic [2:0]
    {
        ST_RESET = 3'h0,
        ST_BOOT = 3'h1,
        ST_ACTIVE = 3'h2,
        ST_PROG_PIN = 3'h3,
        ST_PROG_HOST = 3'h4,
        ST_PROG_NVM = 3'h5
    } rbms_state_t;
endpackage : rbms_pkg

// ### rbms_regs.svh
// constants for the reset and boot-mode sequencer
`ifndef RBMS_REGS_SVH
`define RBMS_REGS_SVH
// ----------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------
`define RBMS_CLK_MHZ 250
`define RBMS_SHORT_US 4000
`define RBMS_PROG_US 5200
`define RBMS_BOOT_US 1000
// cycle counts derived from the figures
`define RBMS_SHORT_CYC (`RBMS_SHORT_US * `RBMS_CLK_MHZ)
`define RBMS_PROG_CYC (`RBMS_PROG_US * `RBMS_CLK_MHZ)
`define RBMS_BOOT_CYC (`RBMS_BOOT_US * `RBMS_CLK_MHZ - 1)
// wake timer: 2 s and 256 s ranges, 8 bit fraction
`define RBMS_WAKE_RANGE_S_SHORT 2
`define RBMS_WAKE_RANGE_S_LONG 256
`define RBMS_WAKE_FRAC_BITS 8
// cause code reset value
`define RBMS_CAUSE_RST 3'h0
`endif

// ### rbms_sequencer.sv
// reset and boot-mode sequencer top
// Contract
// R1: short pin pulse resets into active
// R2: 5.2 ms pin low enters programming
// R3: measure pin low time, classify it
// R4: pins pulled high in active, programming
// R5: programming states hold processor stopped
// R6: host drives reset pin and serial
// R7: host-configured programming needs no pin
// R8: flag sends next reset to programming
// R9: host drives pin and SPI for NVM
// R10: programming opens code and info pages; ST_PROG_NVM leaves them closed
// R11: power-on holds chip in reset
// R12: brown-out forces reset in all modes
// R13: boot sequence finishes within 1 ms
// R14: six reset sources supported
// R15: latch last reset cause for software
// R16: hard resets return pins to input
// R17: wake and soft resets keep pins
// R18: wake timer 2 s or 256 s range
// R19: wake timer self calibrates to clock
// ----------------------------------------------------------------
// shared constants
// ----------------------------------------------------------------
`include "rbms_regs.svh"
module rbms_sequencer
#(
    parameter int SHORT_CYC = `RBMS_SHORT_CYC,
    parameter int PROG_CYC = `RBMS_PROG_CYC,
    parameter int BOOT_CYC = `RBMS_BOOT_CYC
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // reset sources
    input wire logic powerOk,
    input wire logic brownOutN,
    input wire logic resetPinN,
    input wire logic watchdogExpire,
    input wire logic softReset,
    // boot configuration
    input wire logic progNextReset,
    input wire logic nvmProgSelect,
    input wire logic progExit,
    // wake timer
    input wire logic slowTick,
    input wire logic wakeRun,
    input wire logic wakeLongRange,
    input wire logic [7:0] wakeFrac,
    // status
    output rbms_pkg::rbms_cause_t resetCause,
    output rbms_pkg::rbms_state_t bootState,
    // core control
    output logic coreResetN,
    output logic coreRun,
    output logic pinPullUp,
    output logic pinIoReset,
    // programming access
    output logic progListenUart,
    output logic progListenUsb,
    output logic progFlashAccess,
    output logic progSpiEnable
);
    import rbms_pkg::*;
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // sequencer state in one record, apart from the output control flops
    typedef struct packed
    {
        logic [2:0] pinSync;      // pin synchroniser
        logic [2:0] bodSync;      // brown-out synchroniser
        logic [2:0] porSync;      // power-ok synchroniser
        logic brownGood; // supply above brown-out, agreed level
        logic powerGood; // supply up, agreed level
        logic [31:0] lowCnt;      // pin low duration
        logic [31:0] bootCnt;     // boot delay
        logic progFlag;           // sticky programming request
        logic goProg;             // this boot ends in programming
        logic goHost;             // host-configured entry
        rbms_cause_t cause;
        rbms_state_t state;
        logic ioReset;
    } rbms_seq_t;
    rbms_seq_t s_q, s_d;
    logic wakeExpire;
    logic pinLow;
    logic pinRise;
    logic hardHit;
    // ----------------------------------------------------------------
    // wake timer
    // ----------------------------------------------------------------
    // autonomous wake timer, its expiry is a pin-keeping source
    rbms_wake_timer u_wake
    (
        .mclk(mclk),
        .rstn(rstn),
        .slowTick(slowTick),
        .wakeRun(wakeRun),
        .wakeLongRange(wakeLongRange),
        .wakeFrac(wakeFrac),
        .wakeExpire(wakeExpire)
    );
    // ----------------------------------------------------------------
    // pin classification
    // ----------------------------------------------------------------
    // pin low once stages two and three agree; a glitch that only
    // reaches stage one or two never starts a reset
    assign pinLow = !s_q.pinSync[1] && !s_q.pinSync[2];
    // release once both stages read high after a counted low
    assign pinRise = s_q.pinSync[1] && s_q.pinSync[2] && s_q.lowCnt != 0;
    // ----------------------------------------------------------------
    // outputs straight from flops
    // ----------------------------------------------------------------
    assign resetCause = s_q.cause; // readable after boot [R15]
    assign bootState = s_q.state;
    // controls follow the next state, so they switch on the same edge
    // as bootState and never lag it by a cycle
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            coreResetN <= 1'b0;
            coreRun <= 1'b0;
            pinPullUp <= 1'b1;
            pinIoReset <= 1'b1;
            progListenUart <= 1'b0;
            progListenUsb <= 1'b0;
            progFlashAccess <= 1'b0;
            progSpiEnable <= 1'b0;
        end
        else
        begin
            // core runs only in active [R5]
            coreResetN <= s_d.state == ST_ACTIVE;
            coreRun <= s_d.state == ST_ACTIVE;
            // pull-ups in active and programming [R4]
            pinPullUp <= s_d.state != ST_BOOT || s_d.ioReset;
            pinIoReset <= s_d.ioReset; // [R16] [R17]
            progListenUart <= s_d.state == ST_PROG_PIN
                || s_d.state == ST_PROG_HOST; // [R2]
            progListenUsb <= s_d.state == ST_PROG_HOST; // [R8]
            progFlashAccess <= s_d.state == ST_PROG_PIN
                || s_d.state == ST_PROG_HOST; // [R10]
            progSpiEnable <= s_d.state == ST_PROG_NVM; // [R9]
        end
    end
    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.pinSync = {s_q.pinSync[1:0], resetPinN};
        s_d.bodSync = {s_q.bodSync[1:0], brownOutN};
        s_d.porSync = {s_q.porSync[1:0], powerOk};
        hardHit = 1'b0;
        // supply levels change once stages two and three agree, so one
        // noisy sample on a slow supply edge is ignored [R11] [R12]
        if (s_q.porSync[1] == s_q.porSync[2])
            s_d.powerGood = s_q.porSync[2];
        if (s_q.bodSync[1] == s_q.bodSync[2])
            s_d.brownGood = s_q.bodSync[2];
        // flag survives the reset it asks for, cleared only on exit
        // request flag set wins over clear by exit
        if (progNextReset)
            s_d.progFlag = 1'b1; // [R8]
        else if (progExit && s_q.state == ST_PROG_HOST)
            s_d.progFlag = 1'b0;
        // pin low time measured in system clocks [R3]
        if (pinLow)
            s_d.lowCnt = (s_q.lowCnt == 32'hFFFFFFFF) ? s_q.lowCnt
                                                       : s_q.lowCnt + 1;
        else if (s_q.pinSync[1] && s_q.pinSync[2])
            s_d.lowCnt = 32'h0; // cleared only once release is agreed
        // stages disagree: keep the count, the release edge needs it
        // a higher source masks all below it in the same cycle
        // sources by priority [R14]
        if (!s_q.powerGood)
        begin
            s_d.cause = CAUSE_POWER; // held until supply good [R11]
            hardHit = 1'b1;
        end
        else if (!s_q.brownGood)
        begin
            s_d.cause = CAUSE_BROWN; // any state [R12]
            hardHit = 1'b1;
        end
        else if (pinLow)
        begin
            // core stays in reset while the low count runs
            s_d.state = ST_RESET; // hold in reset while pin low
            s_d.ioReset = 1'b1;
        end
        else if (pinRise)
        begin
            s_d.cause = CAUSE_PIN; // on de-assertion [R1]
            hardHit = 1'b1;
            // long hold enters programming, else normal [R2] [R3]
            s_d.goProg = s_q.lowCnt >= 32'(PROG_CYC);
            s_d.goHost = s_q.progFlag;
        end
        else if (watchdogExpire)
        begin
            // watchdog restarts with pins back to input [R16]
            s_d.cause = CAUSE_WDOG;
            hardHit = 1'b1;
        end
        else if (wakeExpire || softReset)
        begin
            // both keep the pins, so io reset stays low
            // pins left alone [R17]
            s_d.cause = softReset ? CAUSE_SOFT : CAUSE_WAKE;
            s_d.state = ST_BOOT;
            s_d.bootCnt = 32'h0;
            s_d.ioReset = 1'b0;
            s_d.goProg = 1'b0;
            s_d.goHost = s_q.progFlag; // soft path too [R7] [R8]
        end
        // hard sources restart the boot with pins back to input; the
        // pin source keeps the programming choice made at release
        if (hardHit)
        begin
            s_d.state = ST_BOOT;
            s_d.bootCnt = 32'h0;
            s_d.ioReset = 1'b1; // pins back to input [R16]
            if (s_d.cause != CAUSE_PIN)
            begin
                s_d.goProg = 1'b0;
                s_d.goHost = s_q.progFlag;
            end
        end
        else
        begin
            case (s_q.state)
                ST_RESET:
                begin
                    // wait in reset for pin release
                    // the release itself is taken as a pin source
                end
                ST_BOOT:
                begin
                    // bring up core within boot time [R13]
                    if (s_q.bootCnt >= 32'(BOOT_CYC))
                    begin
                        s_d.ioReset = 1'b0;
                        if (s_q.goHost)
                            s_d.state = ST_PROG_HOST; // [R7]
                        else if (s_q.goProg && nvmProgSelect)
                            s_d.state = ST_PROG_NVM; // [R9]
                        else if (s_q.goProg)
                            s_d.state = ST_PROG_PIN; // [R6]
                        else
                            s_d.state = ST_ACTIVE; // [R1]
                    end
                    else
                        s_d.bootCnt = s_q.bootCnt + 1;
                end
                ST_ACTIVE, ST_PROG_PIN, ST_PROG_NVM:
                begin
                    // leave only through a reset
                    // or a soft or wake request
                end
                ST_PROG_HOST:
                begin
                    // host ends programming, reboot normal
                    if (progExit)
                    begin
                        s_d.state = ST_BOOT;
                        s_d.bootCnt = 32'h0;
                        s_d.goHost = 1'b0;
                    end
                end
                default:
                    s_d.state = ST_RESET;
            endcase
        end
        // a low time at the short limit is a plain reset: it never
        // programs, and anything up to the programming limit is
        // treated the same way [R3]
        if (s_q.lowCnt == 32'(SHORT_CYC) && !pinLow)
            s_d.goProg = 1'b0;
    end
    // ----------------------------------------------------------------
    // register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            // supply flags start low, so the first boot is a power cause
            s_q <= '0;
            // pin idles high, so no false low follows reset
            s_q.pinSync <= 3'h7;
            s_q.cause <= CAUSE_POWER;
            s_q.state <= ST_RESET;
            s_q.ioReset <= 1'b1;
        end
        else
            s_q <= s_d;
    end
endmodule : rbms_sequencer

// ### rbms_sequencer_properties.sv
// checker of the reset and boot-mode sequencer ports
module rbms_sequencer_properties
import rbms_pkg::*;
#(
    parameter int BOOT_CYC = 10
)
(
    // clock, reset and sources
    input wire logic mclk,
    input wire logic rstn,
    input wire logic powerOk,
    input wire logic brownOutN,
    input wire logic resetPinN,
    // status and control
    input wire rbms_pkg::rbms_cause_t resetCause,
    input wire rbms_pkg::rbms_state_t bootState,
    input wire logic coreResetN,
    input wire logic coreRun,
    input wire logic pinPullUp,
    input wire logic progListenUsb,
    input wire logic progFlashAccess
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // cycles spent in boot since the supply was last good
    int bootCnt_q;
    always_ff @(posedge mclk or negedge rstn)
        if (!rstn)
            bootCnt_q <= 0;
        else
            bootCnt_q <= (bootState == ST_BOOT && powerOk && brownOutN)
                ? bootCnt_q + 1 : 0;
    a_core_run_gated: assert property (coreRun |->
        bootState == ST_ACTIVE && coreResetN) else $error("core runs");
    a_prog_core_held: assert property (bootState inside
        {ST_PROG_PIN, ST_PROG_HOST, ST_PROG_NVM} |-> !coreRun && !coreResetN)
        else $error("core runs in programming");
    a_pull_up_on: assert property (!(bootState inside
        {ST_RESET, ST_BOOT}) |-> pinPullUp) else $error("pull-up off");
    a_power_hold: assert property (!powerOk [*6] |->
        !coreResetN && !coreRun) else $error("core free on low supply");
    a_brown_cause: assert property ((powerOk && !brownOutN) [*6] |->
        !coreResetN && resetCause == CAUSE_BROWN) else $error("brown-out");
    a_pin_low_hold: assert property
        ((powerOk && brownOutN && !resetPinN) [*6] |-> bootState == ST_RESET)
        else $error("pin low not holding");
    a_usb_host_only: assert property (progListenUsb |->
        bootState == ST_PROG_HOST) else $error("usb listen outside host");
    a_flash_access: assert property (progFlashAccess |-> bootState
        inside {ST_PROG_PIN, ST_PROG_HOST}) else $error("flash access");
    // allowance: three supply stages, the agree stage, first boot edge
    a_boot_bounded: assert property (bootCnt_q <= BOOT_CYC + 6)
        else $error("boot too long");
endmodule : rbms_sequencer_properties
bind rbms_sequencer rbms_sequencer_properties #(.BOOT_CYC(BOOT_CYC)) i_props
(
    .mclk(mclk), .rstn(rstn), .powerOk(powerOk), .brownOutN(brownOutN),
    .resetPinN(resetPinN), .resetCause(resetCause), .bootState(bootState),
    .coreResetN(coreResetN), .coreRun(coreRun), .pinPullUp(pinPullUp),
    .progListenUsb(progListenUsb), .progFlashAccess(progFlashAccess)
);

// ### rbms_wake_timer.sv
// wake timer with range select and self calibration
module rbms_wake_timer
#(
    parameter int CAL_W = 32
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // calibration tick from the slow oscillator, already synchronous
    input wire logic slowTick,
    // configuration
    input wire logic wakeRun,
    input wire logic wakeLongRange,
    input wire logic [7:0] wakeFrac,
    // expiry pulse
    output logic wakeExpire
);
    import rbms_pkg::*;
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic [CAL_W-1:0] cycPerTick; // measured clocks per slow tick, less one
        logic [CAL_W-1:0] calCnt;     // running measurement
        logic [CAL_W-1:0] subCnt;     // clocks in current tick
        logic [15:0] tickCnt;         // slow ticks elapsed
        logic expire;
    } rbms_wt_t;
    rbms_wt_t s_q, s_d;
    logic [15:0] target;
    assign wakeExpire = s_q.expire;
    // target in 1/128 s ticks: frac*2/256 s or frac*256/256 s
    assign target = wakeLongRange ? {1'h0, wakeFrac, 7'h00}
                                  : {8'h00, wakeFrac};
    // ----------------------------------------------------------------
    // next state: recalibrate on every slow tick [R19]
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.expire = 1'b0;
        s_d.calCnt = s_q.calCnt + 1'b1;
        if (slowTick)
        begin
            s_d.cycPerTick = s_q.calCnt; // tracks clock drift [R19]
            s_d.calCnt = '0;
        end
        if (!wakeRun)
        begin
            s_d.subCnt = '0;
            s_d.tickCnt = 16'h0000;
        end
        else if (s_q.subCnt >= s_q.cycPerTick)
        begin
            // one calibrated tick elapsed
            s_d.subCnt = '0;
            // the tick that completes the target count expires
            if (s_q.tickCnt + 16'h0001 >= target)
            begin
                s_d.expire = 1'b1; // timeout [R18]
                s_d.tickCnt = 16'h0000;
            end
            else
                s_d.tickCnt = s_q.tickCnt + 16'h0001;
        end
        else
            s_d.subCnt = s_q.subCnt + 1'b1;
    end
    // ----------------------------------------------------------------
    // register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            s_q <= '0;
        else
            s_q <= s_d;
    end
endmodule : rbms_wake_timer

// ### tb_top.sv
// testbench of the reset and boot-mode sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rbms_pkg::*;
    logic mclk = 0, rstn = 0, powerOk = 0, brownOutN = 1, slowTick = 0;
    logic watchdogExpire = 0, softReset = 0, progNextReset = 0;
    logic nvmProgSelect = 0, progExit = 0, wakeRun = 0, wakeLongRange = 0;
    logic [7:0] wakeFrac = 8'h00, pulseLen = 8'h00;
    logic pulseGo = 0, resetPinN, busy, coreResetN, coreRun, pinPullUp;
    logic pinIoReset, progListenUart, progListenUsb, progFlashAccess;
    logic progSpiEnable, io, nvm, lng;
    rbms_cause_t resetCause;
    rbms_state_t bootState;
    int bad_count = 0, n_checks = 0, cyc = 0, i, t0;
    // device and outside host
    rbms_sequencer #(.SHORT_CYC(40), .PROG_CYC(52), .BOOT_CYC(10))
        i_rbms_sequencer (.mclk(mclk), .rstn(rstn), .powerOk(powerOk),
        .brownOutN(brownOutN), .resetPinN(resetPinN),
        .watchdogExpire(watchdogExpire), .softReset(softReset),
        .progNextReset(progNextReset), .nvmProgSelect(nvmProgSelect),
        .progExit(progExit), .slowTick(slowTick), .wakeRun(wakeRun),
        .wakeLongRange(wakeLongRange), .wakeFrac(wakeFrac),
        .resetCause(resetCause), .bootState(bootState),
        .coreResetN(coreResetN), .coreRun(coreRun), .pinPullUp(pinPullUp),
        .pinIoReset(pinIoReset), .progListenUart(progListenUart),
        .progListenUsb(progListenUsb), .progFlashAccess(progFlashAccess),
        .progSpiEnable(progSpiEnable));
    rbms_host_model i_rbms_host_model (.mclk(mclk), .pulseGo(pulseGo),
        .pulseLen(pulseLen), .resetPinN(resetPinN), .busy(busy));
    initial
        forever #2 mclk = ~mclk;
    // slow tick, cycle limit
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        slowTick <= (cyc % 16 == 0);
        if (cyc == 40000)
        begin
            bad_count++;
            stop_test();
        end
    end
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // wait through boot, noting io reset
    task settle(output logic ioHit);
        logic booted;
        booted = 0;
        ioHit = 0;
        for (int k = 0; k < 3000; k++)
        begin
            @(posedge mclk);
            #1;
            ioHit |= pinIoReset;
            booted |= (bootState === ST_BOOT);
            if (booted && !(bootState inside {ST_RESET, ST_BOOT}))
                break;
        end
    endtask : settle
    task stop_test();
        if (bad_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    initial
    begin
        void'($urandom(84526));
        repeat (5) @(posedge mclk);
        rstn <= 1;
        powerOk <= 1;
        settle(io);
        chk("cause", resetCause, CAUSE_POWER);
        chk("state", bootState, ST_ACTIVE);
        chk("pullup", pinPullUp, 1);
        // random pin pulses, short and long
        for (i = 0; i < 8; i++)
        begin
            nvm = $urandom;
            lng = $urandom;
            @(posedge mclk);
            nvmProgSelect <= nvm;
            pulseLen <= lng ? 8'(60 + $urandom % 40) : 8'(4 + $urandom % 44);
            pulseGo <= 1;
            @(posedge mclk) pulseGo <= 0;
            settle(io);
            chk("state", bootState, !lng ? ST_ACTIVE :
                nvm ? ST_PROG_NVM : ST_PROG_PIN);
            chk("cause", resetCause, CAUSE_PIN);
            chk("io", io, 1);
            chk("run", coreRun, !lng);
            chk("uart", progListenUart, lng && !nvm);
            chk("spi", progSpiEnable, lng && nvm);
        end
        // flag then soft reset into host programming
        @(posedge mclk) progNextReset <= 1;
        @(posedge mclk) progNextReset <= 0;
        softReset <= 1;
        @(posedge mclk) softReset <= 0;
        settle(io);
        chk("state", bootState, ST_PROG_HOST);
        chk("usb", progListenUsb, 1);
        chk("cause", resetCause, CAUSE_SOFT);
        chk("io", io, 0);
        @(posedge mclk) progExit <= 1;
        @(posedge mclk) progExit <= 0;
        repeat (20) @(posedge mclk);
        chk("exit", bootState === ST_PROG_HOST, 0);
        watchdogExpire <= 1;
        @(posedge mclk) watchdogExpire <= 0;
        settle(io);
        chk("state", bootState, ST_ACTIVE);
        chk("cause", resetCause, CAUSE_WDOG);
        chk("io", io, 1);
        // supply events
        @(posedge mclk) brownOutN <= 0;
        repeat (8) @(posedge mclk);
        brownOutN <= 1;
        settle(io);
        chk("cause", resetCause, CAUSE_BROWN);
        chk("io", io, 1);
        @(posedge mclk) powerOk <= 0;
        repeat (8) @(posedge mclk);
        powerOk <= 1;
        settle(io);
        chk("cause", resetCause, CAUSE_POWER);
        // wake timer, short range
        @(posedge mclk);
        wakeFrac <= 8'(2 + $urandom % 4);
        wakeRun <= 1;
        settle(io);
        chk("cause", resetCause, CAUSE_WAKE);
        chk("io", io, 0);
        @(posedge mclk) wakeRun <= 0;
        // long range, one step is one second: 128 ticks of 16 cycles
        @(posedge mclk);
        wakeLongRange <= 1;
        wakeFrac <= 8'h01;
        wakeRun <= 1;
        t0 = cyc;
        settle(io);
        chk("wakelong", (cyc - t0) inside {[2048:2100]}, 1);
        chk("cause", resetCause, CAUSE_WAKE);
        @(posedge mclk) wakeRun <= 0;
        stop_test();
    end
endmodule : tb_top
